// >>> include/supply_fault_pkg.sv
package supply_fault_pkg;
  localparam int CHANNEL_COUNT = 2;
  localparam int SYNC_STAGES = 2;
  // fast turn-off: outputs drop on the first edge after a synchronised fault
  localparam logic [1:0] CHANNELS_OFF = 2'h0;
  localparam logic FAULT_PIN_IDLE = 1'h1;
  localparam logic FLAG_CLEAR = 1'h0;

  typedef enum logic [1:0] {
    CTRL_SERIAL,
    CTRL_DIRECT,
    CTRL_FAILSAFE
  } control_mode_type;
endpackage : supply_fault_pkg

// >>> verilog/level_sync.sv
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;

  // the first stage feeds only the second one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule : level_sync

// >>> verilog/supply_fault_manager.sv
`timescale 1ns/100ps
module supply_fault_manager
  import supply_fault_pkg::*;
#(
  parameter int CHANNELS = CHANNEL_COUNT
) (
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                undervoltage_in,
  input  wire logic                below_6v_in,
  input  wire logic                overvoltage_in,
  input  wire logic                logic_supply_fail_in,
  input  wire logic                supply_por_in,
  input  wire logic                load_ground_loss_in,
  input  wire logic                system_ground_loss_in,
  input  wire logic                device_ground_high_in,
  input  wire logic [CHANNELS-1:0] overtemp_in,
  input  wire logic [CHANNELS-1:0] overcurrent_in,
  input  wire logic [CHANNELS-1:0] short_in,
  input  wire logic [CHANNELS-1:0] direct_in,
  input  wire logic [CHANNELS-1:0] serial_request_in,
  input  wire logic [CHANNELS-1:0] delatch_in,
  input  wire logic                por_sequence_in,
  input  wire logic                status_read_in,
  input  wire logic                overvoltage_disable_in,
  input  wire logic                logic_fail_enable_in,
  input  wire logic                retry_enable_in,
  output logic [CHANNELS-1:0]      output_channel_out,
  output logic                     fault_status_n_out,
  output logic                     undervoltage_flag_out,
  output logic                     overvoltage_flag_out,
  output logic [CHANNELS-1:0]      overtemp_fault_out,
  output logic [CHANNELS-1:0]      overcurrent_fault_out,
  output logic [CHANNELS-1:0]      short_fault_out,
  output logic                     open_load_flag_out,
  output logic                     serial_enable_out,
  output logic                     retry_start_out,
  output logic [1:0]               control_mode_out
);
  localparam int MON = 9 + 4 * CHANNELS;

  logic                rst_sync1_q;
  logic                rst_q;
  logic [MON-1:0]      mon_raw;
  logic [MON-1:0]      mon;
  logic                uv;
  logic                uv_prev_q;
  logic                below6;
  logic                ov;
  logic                vdd_fail;
  logic                por;
  logic                load_gnd;
  logic                sys_gnd;
  logic                gnd_high;
  logic [CHANNELS-1:0] ot;
  logic [CHANNELS-1:0] oc;
  logic [CHANNELS-1:0] sc;
  logic [CHANNELS-1:0] din;
  logic                uv_fall;
  logic                clear_all;
  logic                read_ok;
  logic [CHANNELS-1:0] armed_q;
  logic                uv_latched_q;
  logic [CHANNELS-1:0] ot_pending_q;
  logic [CHANNELS-1:0] request;
  logic                shared_off;
  logic                ov_fault_active;
  control_mode_type    mode_q;
  control_mode_type    mode_d;

  // reset released through two flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync1_q <= 1'h0;
      rst_q       <= 1'h0;
    end else begin
      rst_sync1_q <= 1'h1;
      rst_q       <= rst_sync1_q;
    end
  end

  assign mon_raw = {direct_in, short_in, overcurrent_in, overtemp_in, device_ground_high_in,
                    system_ground_loss_in, load_ground_loss_in, supply_por_in, logic_supply_fail_in,
                    overvoltage_in, below_6v_in, undervoltage_in, 1'h0};

  level_sync #(
    .WIDTH(MON)
  ) u_mon_sync (
    .clk_in  (clk_in),
    .rst_n_in(rst_q),
    .async_in(mon_raw),
    .sync_out(mon)
  );

  assign uv       = mon[1];
  assign below6   = mon[2];
  assign ov       = mon[3];
  assign vdd_fail = mon[4];
  assign por      = mon[5];
  assign load_gnd = mon[6];
  assign sys_gnd  = mon[7];
  assign gnd_high = mon[8];
  assign ot       = mon[9 +: CHANNELS];
  assign oc       = mon[9 + CHANNELS +: CHANNELS];
  assign sc       = mon[9 + 2 * CHANNELS +: CHANNELS];
  assign din      = mon[9 + 3 * CHANNELS +: CHANNELS];

  assign uv_fall = uv_prev_q && !uv;
  // logic supply failing counts only with a normal power supply or while supply por is present
  assign clear_all = (vdd_fail && !uv) || (vdd_fail && por);
  // a read counts only while the serial output is enabled; fault bits also need the cause gone and a delatch
  assign read_ok = status_read_in && serial_enable_out;

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      uv_prev_q <= 1'h0;
    end else begin
      uv_prev_q <= uv;
    end
  end

  // control source selection; ground high wins over supply-based choice
  always_comb begin
    mode_d = mode_q;
    if (gnd_high) begin
      mode_d = CTRL_FAILSAFE;
    end else if (vdd_fail && logic_fail_enable_in) begin
      mode_d = CTRL_DIRECT;
    end else if (!vdd_fail) begin
      mode_d = CTRL_SERIAL;
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      mode_q <= CTRL_SERIAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // serial output only while logic supply holds and ground is low; undervoltage does not stop it
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      serial_enable_out <= 1'h0;
    end else begin
      serial_enable_out <= !vdd_fail && !gnd_high;
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      control_mode_out <= 2'h0;
    end else begin
      control_mode_out <= mode_d;
    end
  end

  // turn-on permission after undervoltage: delatch or por must come first
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      armed_q <= '1;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (delatch_in[i] || por_sequence_in || por) begin
          armed_q[i] <= 1'h1;
        end else if (uv) begin
          armed_q[i] <= 1'h0;
        end
      end
    end
  end

  // undervoltage flag: set wins; warning case clears on turn-on, active case on read
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      undervoltage_flag_out <= FLAG_CLEAR;
      uv_latched_q          <= 1'h0;
    end else if (uv) begin
      undervoltage_flag_out <= 1'h1;
      uv_latched_q          <= 1'h0;
    end else if (clear_all) begin
      undervoltage_flag_out <= FLAG_CLEAR;
      uv_latched_q          <= 1'h0;
    end else if (uv_fall) begin
      uv_latched_q <= |request;
    end else if (uv_latched_q) begin
      if (read_ok) begin
        undervoltage_flag_out <= FLAG_CLEAR;
        uv_latched_q          <= 1'h0;
      end
    end else if (|output_channel_out) begin
      undervoltage_flag_out <= FLAG_CLEAR;
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      overvoltage_flag_out <= FLAG_CLEAR;
    end else if (ov) begin
      overvoltage_flag_out <= 1'h1;
    end else if (clear_all || read_ok) begin
      overvoltage_flag_out <= FLAG_CLEAR;
    end
  end

  // per-channel latched faults; settings otherwise hold through extended range
  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_fault
      logic can_clear;
      assign can_clear = read_ok && delatch_in[g];

      always_ff @(posedge clk_in or negedge rst_q) begin
        if (!rst_q) begin
          ot_pending_q[g]          <= 1'h0;
          overtemp_fault_out[g]    <= FLAG_CLEAR;
          overcurrent_fault_out[g] <= FLAG_CLEAR;
          short_fault_out[g]       <= FLAG_CLEAR;
        end else if (clear_all && !(ot[g] || oc[g] || sc[g])) begin
          ot_pending_q[g]          <= 1'h0;
          overtemp_fault_out[g]    <= FLAG_CLEAR;
          overcurrent_fault_out[g] <= FLAG_CLEAR;
          short_fault_out[g]       <= FLAG_CLEAR;
        end else begin
          // below 6 V only overtemperature is watched, and its record waits for the supply
          if (ot[g] && uv) begin
            ot_pending_q[g] <= 1'h1;
          end else if (!uv) begin
            ot_pending_q[g] <= 1'h0;
          end
          if ((ot[g] && !uv) || (ot_pending_q[g] && !uv)) begin
            overtemp_fault_out[g] <= 1'h1;
          end else if (can_clear && !ot[g]) begin
            overtemp_fault_out[g] <= FLAG_CLEAR;
          end
          if (oc[g] && !below6) begin
            overcurrent_fault_out[g] <= 1'h1;
          end else if (can_clear && !oc[g]) begin
            overcurrent_fault_out[g] <= FLAG_CLEAR;
          end
          if (sc[g] && !below6) begin
            short_fault_out[g] <= 1'h1;
          end else if (can_clear && !sc[g]) begin
            short_fault_out[g] <= FLAG_CLEAR;
          end
        end
      end
    end
  endgenerate

  // channel requests by control source
  always_comb begin
    unique case (mode_q)
      CTRL_SERIAL:   request = serial_request_in;
      CTRL_DIRECT:   request = uv ? CHANNELS_OFF : din;
      CTRL_FAILSAFE: request = din;
      default:       request = CHANNELS_OFF;
    endcase
  end

  assign ov_fault_active = ov && !overvoltage_disable_in;
  assign shared_off = uv || sys_gnd || ov_fault_active;

  // direct drive from the flop: faults cut the gate without the slew ramp
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      output_channel_out <= CHANNELS_OFF;
    end else if (shared_off) begin
      output_channel_out <= CHANNELS_OFF;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        output_channel_out[i] <= request[i] && armed_q[i] && !ot[i]
                                 && !(below6 ? 1'h0 : (oc[i] || sc[i]));
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      fault_status_n_out <= FAULT_PIN_IDLE;
    end else begin
      fault_status_n_out <= !(uv || ov_fault_active || (|ot) || (|oc) || (|sc));
    end
  end

  // load ground loss leaves channel states alone and flags open load
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      open_load_flag_out <= FLAG_CLEAR;
    end else if (load_gnd) begin
      open_load_flag_out <= 1'h1;
    end else if (clear_all || read_ok) begin
      open_load_flag_out <= FLAG_CLEAR;
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      retry_start_out <= 1'h0;
    end else begin
      retry_start_out <= uv_fall && retry_enable_in;
    end
  end
endmodule : supply_fault_manager

// >>> bench/supply_fault_checker.sv
`timescale 1ns/100ps
module supply_fault_checker
  import supply_fault_pkg::*;
#(
  parameter int CHANNELS = CHANNEL_COUNT
) (
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  input wire logic                undervoltage_in,
  input wire logic                below_6v_in,
  input wire logic                overvoltage_in,
  input wire logic                overvoltage_disable_in,
  input wire logic                logic_supply_fail_in,
  input wire logic                logic_fail_enable_in,
  input wire logic                load_ground_loss_in,
  input wire logic                system_ground_loss_in,
  input wire logic                device_ground_high_in,
  input wire logic [CHANNELS-1:0] short_in,
  input wire logic                retry_enable_in,
  input wire logic [CHANNELS-1:0] output_channel_out,
  input wire logic                fault_status_n_out,
  input wire logic                undervoltage_flag_out,
  input wire logic                overvoltage_flag_out,
  input wire logic                open_load_flag_out,
  input wire logic                serial_enable_out,
  input wire logic                retry_start_out,
  input wire logic [1:0]          control_mode_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // seven samples cover internal reset release, two sync flops and the decision edge
  sequence held(s);
    s [*7];
  endsequence
  chk_uv_off: assert property (held(undervoltage_in) |-> output_channel_out == CHANNELS_OFF
    && !fault_status_n_out && undervoltage_flag_out) else $error("undervoltage shutdown missing");
  chk_ov_off: assert property (held(overvoltage_in && !overvoltage_disable_in) |->
    output_channel_out == CHANNELS_OFF && !fault_status_n_out && overvoltage_flag_out) else $error("ov shutdown missing");
  chk_ov_warn: assert property (held(overvoltage_in) |-> overvoltage_flag_out)
    else $error("ov flag missing");
  chk_sgnd_off: assert property (held(system_ground_loss_in) |-> output_channel_out == CHANNELS_OFF)
    else $error("ground loss left channel on");
  chk_lgnd_flag: assert property (held(load_ground_loss_in) |-> open_load_flag_out)
    else $error("open load flag missing");
  chk_gnd_failsafe: assert property (held(device_ground_high_in) |->
    control_mode_out == CTRL_FAILSAFE && !serial_enable_out) else $error("failsafe not entered");
  chk_direct_mode: assert property (held(logic_supply_fail_in && logic_fail_enable_in && !device_ground_high_in) |->
    control_mode_out == CTRL_DIRECT) else $error("direct control not taken");
  chk_serial_kept: assert property (held(logic_supply_fail_in && !logic_fail_enable_in && !device_ground_high_in) |->
    control_mode_out == CTRL_SERIAL) else $error("serial control dropped");
  chk_serial_alive: assert property (held((undervoltage_in || overvoltage_in) && !logic_supply_fail_in
    && !device_ground_high_in) |-> serial_enable_out) else $error("serial port lost");
  chk_short_off: assert property (held(short_in[0] && !below_6v_in) |-> !output_channel_out[0])
    else $error("short left channel on");
  chk_retry_pulse: assert property (retry_start_out |-> $past(retry_enable_in) ##1 !retry_start_out)
    else $error("bad retry pulse");
endmodule : supply_fault_checker

bind supply_fault_manager supply_fault_checker #(.CHANNELS(CHANNELS)) checker_i (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .undervoltage_in(undervoltage_in), .below_6v_in(below_6v_in),
  .overvoltage_in(overvoltage_in), .overvoltage_disable_in(overvoltage_disable_in),
  .logic_supply_fail_in(logic_supply_fail_in), .logic_fail_enable_in(logic_fail_enable_in),
  .load_ground_loss_in(load_ground_loss_in), .system_ground_loss_in(system_ground_loss_in),
  .device_ground_high_in(device_ground_high_in), .short_in(short_in), .retry_enable_in(retry_enable_in),
  .output_channel_out(output_channel_out), .fault_status_n_out(fault_status_n_out),
  .undervoltage_flag_out(undervoltage_flag_out), .overvoltage_flag_out(overvoltage_flag_out),
  .open_load_flag_out(open_load_flag_out), .serial_enable_out(serial_enable_out),
  .retry_start_out(retry_start_out), .control_mode_out(control_mode_out));

// >>> bench/host_model.sv
`timescale 1ns/100ps
module host_model (
  input  wire logic  clk_in,
  output logic [1:0] serial_request_out,
  output logic [1:0] delatch_out,
  output logic       por_sequence_out,
  output logic       status_read_out,
  output logic       wake_reset_n_out
);
  initial begin
    serial_request_out = 2'h0;
    delatch_out = 2'h0;
    por_sequence_out = 1'h0;
    status_read_out = 1'h0;
    wake_reset_n_out = 1'h1;
  end
  task automatic request(input logic [1:0] v);
    serial_request_out = v;
  endtask : request
  // called at a falling edge, so each strobe spans exactly one rising edge
  task automatic strobe(input logic p, input logic r, input logic [1:0] d);
    por_sequence_out = p;
    status_read_out = r;
    delatch_out = d;
    @(negedge clk_in);
    por_sequence_out = 1'h0;
    status_read_out = 1'h0;
    delatch_out = 2'h0;
  endtask : strobe
endmodule : host_model

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [7:0] cond;
    logic [1:0] sc, ch, chm;
    logic       fsn, fsc;
    logic [1:0] md;
    logic [2:0] fl, flm;
  } row_type;
  logic       clk, arst_n, uv, b6, ov, lsf, spor, lgnd, sgnd, dgnd, ovdis, lfe, rte;
  logic [1:0] ot, oc, sc, dir, req, dl, ch, otf, ocf, scf, mode;
  logic       por, rd, fsn, uvf, ovf, olf, sen, rty;
  int         failures = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         n;
  row_type    rows [10];
  supply_fault_manager dut (.clk_in(clk), .arst_n_in(arst_n), .undervoltage_in(uv), .below_6v_in(b6),
    .overvoltage_in(ov), .logic_supply_fail_in(lsf), .supply_por_in(spor), .load_ground_loss_in(lgnd),
    .system_ground_loss_in(sgnd), .device_ground_high_in(dgnd), .overtemp_in(ot), .overcurrent_in(oc),
    .short_in(sc), .direct_in(dir), .serial_request_in(req), .delatch_in(dl), .por_sequence_in(por),
    .status_read_in(rd), .overvoltage_disable_in(ovdis), .logic_fail_enable_in(lfe), .retry_enable_in(rte),
    .output_channel_out(ch), .fault_status_n_out(fsn), .undervoltage_flag_out(uvf),
    .overvoltage_flag_out(ovf), .overtemp_fault_out(otf), .overcurrent_fault_out(ocf),
    .short_fault_out(scf), .open_load_flag_out(olf), .serial_enable_out(sen), .retry_start_out(rty),
    .control_mode_out(mode));
  host_model host (.clk_in(clk), .serial_request_out(req), .delatch_out(dl), .por_sequence_out(por),
    .status_read_out(rd), .wake_reset_n_out());
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // each case starts from reset so sticky flags of the last case cannot mask the next
  task automatic restart();
    arst_n = 1'h0;
    step(2);
    arst_n = 1'h1;
    step(3);
    // requests left on by an earlier case would turn a warning recovery into an active one
    host.request(2'h0);
    host.strobe(1'h1, 1'h0, 2'h0);
  endtask : restart
  // ceiling well above the roughly 300 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {uv, b6, ov, lsf, spor, lgnd, sgnd, dgnd, ovdis, lfe, rte} = 11'h000;
    {ot, oc, sc, dir} = 8'h00;
    arst_n = 1'h0;
    rows[0] = '{8'h00, 2'h0, 2'h3, 2'h3, 1'h1, 1'h1, 2'h0, 3'h0, 3'h7};
    rows[1] = '{8'h80, 2'h0, 2'h0, 2'h3, 1'h0, 1'h1, 2'h0, 3'h4, 3'h7};
    rows[2] = '{8'h40, 2'h0, 2'h0, 2'h3, 1'h0, 1'h1, 2'h0, 3'h2, 3'h7};
    rows[3] = '{8'h60, 2'h0, 2'h3, 2'h3, 1'h1, 1'h1, 2'h0, 3'h2, 3'h7};
    rows[4] = '{8'h10, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0, 2'h0, 3'h0, 3'h0};
    rows[5] = '{8'h08, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0, 2'h0, 3'h1, 3'h1};
    rows[6] = '{8'h04, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h2, 3'h0, 3'h0};
    rows[7] = '{8'h03, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0, 2'h1, 3'h0, 3'h0};
    rows[8] = '{8'h02, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0, 2'h0, 3'h0, 3'h0};
    rows[9] = '{8'h00, 2'h1, 2'h2, 2'h3, 1'h0, 1'h1, 2'h0, 3'h0, 3'h7};
    step(5);
    for (int i = 0; i < 10; i++) begin
      restart();
      host.request(2'h3);
      {uv, ov, ovdis, sgnd, lgnd, dgnd, lsf, lfe} = rows[i].cond;
      sc = rows[i].sc;
      step(8);
      chk("channels", 4'(rows[i].ch & rows[i].chm), 4'(ch & rows[i].chm));
      if (rows[i].fsc) chk("fault_pin", 4'(rows[i].fsn), 4'(fsn));
      chk("mode", 4'(rows[i].md), 4'(mode));
      chk("flags", 4'(rows[i].fl & rows[i].flm), 4'({uvf, ovf, olf} & rows[i].flm));
      if (rows[i].sc != 2'h0) chk("short", 4'(rows[i].sc), 4'(scf));
      {uv, ov, ovdis, sgnd, lgnd, dgnd, lsf, lfe} = 8'h00;
      sc = 2'h0;
    end
    restart();
    uv = 1'h1;
    step(8);
    uv = 1'h0;
    step(8);
    chk("fault_pin", 4'h1, 4'(fsn));
    chk("uv_flag", 4'h1, 4'(uvf));
    host.strobe(1'h0, 1'h0, 2'h3);
    host.request(2'h3);
    step(4);
    chk("channels", 4'h3, 4'(ch));
    chk("uv_flag", 4'h0, 4'(uvf));
    restart();
    host.request(2'h3);
    uv = 1'h1;
    step(8);
    uv = 1'h0;
    step(8);
    chk("channels", 4'h0, 4'(ch));
    host.strobe(1'h0, 1'h0, 2'h3);
    step(4);
    chk("channels", 4'h3, 4'(ch));
    chk("uv_flag", 4'h1, 4'(uvf));
    host.strobe(1'h0, 1'h1, 2'h0);
    step(3);
    chk("uv_flag", 4'h0, 4'(uvf));
    restart();
    rte = 1'h1;
    uv = 1'h1;
    step(8);
    uv = 1'h0;
    n = 0;
    repeat (8) begin
      step(1);
      n += int'(rty);
    end
    chk("retry", 4'h1, 4'(n));
    rte = 1'h0;
    restart();
    host.request(2'h3);
    oc = 2'h2;
    step(8);
    chk("oc_fault", 4'h2, 4'(ocf));
    chk("channels", 4'h1, 4'(ch));
    oc = 2'h0;
    restart();
    host.request(2'h3);
    {b6, uv, ot} = 4'hD;
    step(8);
    chk("ot_fault", 4'h0, 4'(otf));
    // cause gone while still low: the record must still appear once the supply is back
    ot = 2'h0;
    step(4);
    {b6, uv} = 2'h0;
    step(8);
    chk("ot_fault", 4'h1, 4'(otf));
    ot = 2'h0;
    step(6);
    host.strobe(1'h0, 1'h1, 2'h0);
    step(3);
    chk("ot_fault", 4'h1, 4'(otf));
    host.strobe(1'h0, 1'h1, 2'h1);
    step(3);
    chk("ot_fault", 4'h0, 4'(otf));
    ot = 2'h1;
    step(8);
    ot = 2'h0;
    lsf = 1'h1;
    step(8);
    chk("ot_fault", 4'h0, 4'(otf));
    ot = 2'h1;
    step(8);
    chk("fault_pin", 4'h0, 4'(fsn));
    chk("serial", 4'h0, 4'(sen));
    wrap_up();
  end
endmodule : tb
